// ===== hdl/mbst_map.vh
`ifndef MBST_MAP_VH
`define MBST_MAP_VH

// Register lengths
`define MBST_IR_LEN 3
`define MBST_ID_LEN 32
`define MBST_BSR_LEN 107

// Instruction opcodes
`define MBST_OP_EXTEST 3'h0
`define MBST_OP_IDCODE 3'h1
`define MBST_OP_SAMPZ 3'h2
`define MBST_OP_SAMPLE 3'h4
`define MBST_OP_BYPASS 3'h7

// Instruction capture pattern and reset values
`define MBST_IR_CAPTURE 3'h1
`define MBST_IR_RESET `MBST_OP_IDCODE
`define MBST_BYPASS_RESET 1'h0

// Identification fields, values arbitrary
`define MBST_ID_REV 4'h0
`define MBST_ID_PART 16'h0abc
`define MBST_ID_VENDOR 11'h2a5
`define MBST_ID_FIX 1'h1

// State codes
`define MBST_ST_RESET 4'h0
`define MBST_ST_IDLE 4'h1
`define MBST_ST_SEL_DR 4'h2
`define MBST_ST_CAP_DR 4'h3
`define MBST_ST_SH_DR 4'h4
`define MBST_ST_EX1_DR 4'h5
`define MBST_ST_PA_DR 4'h6
`define MBST_ST_EX2_DR 4'h7
`define MBST_ST_UPD_DR 4'h8
`define MBST_ST_SEL_IR 4'h9
`define MBST_ST_CAP_IR 4'ha
`define MBST_ST_SH_IR 4'hb
`define MBST_ST_EX1_IR 4'hc
`define MBST_ST_PA_IR 4'hd
`define MBST_ST_EX2_IR 4'he
`define MBST_ST_UPD_IR 4'hf
`endif

// ===== hdl/mbst_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for levels from outside the clock domain
module mbst_sync #(
  parameter WIDTH = 1
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // First stage feeds only the second
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;
endmodule

// ===== hdl/mbst_tap_fsm.v
`timescale 1ns/100ps
`include "mbst_map.vh"
// Sixteen-state test controller, stepped once per test clock rise
module mbst_tap_fsm (
  input wire clk_sys_i,
  input wire reset_i,
  input wire step_i,
  input wire tms_i,
  output wire [3:0] state_o
);
  localparam ST_RESET = `MBST_ST_RESET;
  localparam ST_IDLE = `MBST_ST_IDLE;
  localparam ST_SEL_DR = `MBST_ST_SEL_DR;
  localparam ST_CAP_DR = `MBST_ST_CAP_DR;
  localparam ST_SH_DR = `MBST_ST_SH_DR;
  localparam ST_EX1_DR = `MBST_ST_EX1_DR;
  localparam ST_PA_DR = `MBST_ST_PA_DR;
  localparam ST_EX2_DR = `MBST_ST_EX2_DR;
  localparam ST_UPD_DR = `MBST_ST_UPD_DR;
  localparam ST_SEL_IR = `MBST_ST_SEL_IR;
  localparam ST_CAP_IR = `MBST_ST_CAP_IR;
  localparam ST_SH_IR = `MBST_ST_SH_IR;
  localparam ST_EX1_IR = `MBST_ST_EX1_IR;
  localparam ST_PA_IR = `MBST_ST_PA_IR;
  localparam ST_EX2_IR = `MBST_ST_EX2_IR;
  localparam ST_UPD_IR = `MBST_ST_UPD_IR;

  reg [3:0] state;
  reg [3:0] next_state;

  // Transition table; mode select is the only steering input
  always @* begin
    case (state)
      ST_RESET: next_state = tms_i ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_i ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_state = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_i ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: next_state = tms_i ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = tms_i ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_i ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_state = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_i ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: next_state = tms_i ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = tms_i ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms_i ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  // Power-up reset, then one step per qualified rise
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_RESET;
    end else if (step_i) begin
      state <= next_state;
    end
  end

  assign state_o = state;
endmodule

// ===== hdl/mbst_tap.v
`timescale 1ns/100ps
`include "mbst_map.vh"
// Boundary-scan test port of the memory.
// The test clock is sampled by the system clock; its edges become
// one-cycle pulses. No reset pin exists on the test side: the
// controller walks to reset with mode select high.
// Only bypass, identification and boundary scan are provided.
module mbst_tap #(
  parameter BSR_LEN = `MBST_BSR_LEN,
  parameter [3:0] ID_REV = `MBST_ID_REV, // Value arbitrary
  parameter [15:0] ID_PART = `MBST_ID_PART, // Value arbitrary
  parameter [10:0] ID_VENDOR = `MBST_ID_VENDOR // Value arbitrary
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire [BSR_LEN-1:0] io_ring_i,
  output wire tdo_o,
  output wire tdo_oe_o,
  output wire [3:0] tap_state_o,
  output wire [2:0] instr_o,
  output wire [BSR_LEN-1:0] bnd_update_o,
  output wire bnd_drive_o,
  output wire io_hiz_o
);
  localparam IR_LEN = `MBST_IR_LEN;
  localparam ID_LEN = `MBST_ID_LEN;

  // Identification word, fixed bit in the lowest place
  localparam [ID_LEN-1:0] ID_WORD = {ID_REV, ID_PART, ID_VENDOR, `MBST_ID_FIX};

  wire [2:0] pins_s;
  wire [BSR_LEN-1:0] ring_s;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire [3:0] state;

  reg tck_d;
  wire tck_rise;
  wire tck_fall;

  reg [IR_LEN-1:0] ir_shift;
  reg [IR_LEN-1:0] ir;
  reg bypass;
  reg [ID_LEN-1:0] id_shift;
  reg [BSR_LEN-1:0] bsr_shift;
  reg [BSR_LEN-1:0] bsr_update;
  reg bnd_drive;
  reg io_hiz;
  reg tdo;
  reg tdo_oe;

  wire [BSR_LEN-1:0] next_bsr;
  reg next_tdo;

  wire sel_bsr;
  wire sel_id;
  wire sel_byp;
  wire st_reset;
  wire st_cap_dr;
  wire st_sh_dr;
  wire st_upd_dr;
  wire st_cap_ir;
  wire st_sh_ir;
  wire st_upd_ir;

  // Pins cross into the system clock domain
  mbst_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i({tck_i, tms_i, tdi_i}),
    .sync_o(pins_s)
  );

  // I/O ring levels cross the same way before capture
  mbst_sync #(
    .WIDTH(BSR_LEN)
  ) u_ring_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i(io_ring_i),
    .sync_o(ring_s)
  );

  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];

  // Test clock edge finder on the synchronised level
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // Controller state machine, stepped by mode select on each rise
  mbst_tap_fsm u_fsm (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .step_i(tck_rise),
    .tms_i(tms_s),
    .state_o(state)
  );

  // State decodes
  assign st_reset = (state == `MBST_ST_RESET);
  assign st_cap_dr = (state == `MBST_ST_CAP_DR);
  assign st_sh_dr = (state == `MBST_ST_SH_DR);
  assign st_upd_dr = (state == `MBST_ST_UPD_DR);
  assign st_cap_ir = (state == `MBST_ST_CAP_IR);
  assign st_sh_ir = (state == `MBST_ST_SH_IR);
  assign st_upd_ir = (state == `MBST_ST_UPD_IR);

  // Data register chosen by the active instruction
  assign sel_bsr = (ir == `MBST_OP_EXTEST) | (ir == `MBST_OP_SAMPLE) | (ir == `MBST_OP_SAMPZ);
  assign sel_id = (ir == `MBST_OP_IDCODE);
  assign sel_byp = ~sel_bsr & ~sel_id;

  // Instruction shift stage: captures pattern, shifts only on its own path
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ir_shift <= `MBST_IR_CAPTURE;
    end else if (tck_rise) begin
      if (st_cap_ir) begin
        ir_shift <= `MBST_IR_CAPTURE;
      end else if (st_sh_ir) begin
        ir_shift <= {tdi_s, ir_shift[IR_LEN-1:1]};
      end
    end
  end

  // Active instruction: preset in reset state, loaded on update
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ir <= `MBST_IR_RESET;
    end else if (st_reset) begin
      ir <= `MBST_IR_RESET;
    end else if (tck_rise && st_upd_ir) begin
      ir <= ir_shift;
    end
  end

  // Bypass bit: captures zero, then passes one bit through
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bypass <= `MBST_BYPASS_RESET;
    end else if (tck_rise && sel_byp) begin
      if (st_cap_dr) begin
        bypass <= `MBST_BYPASS_RESET;
      end else if (st_sh_dr) begin
        bypass <= tdi_s;
      end
    end
  end

  // Identification register: capture the fixed word, then shift
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      id_shift <= {ID_LEN{1'b0}};
    end else if (tck_rise && sel_id) begin
      if (st_cap_dr) begin
        id_shift <= ID_WORD;
      end else if (st_sh_dr) begin
        id_shift <= {tdi_s, id_shift[ID_LEN-1:1]};
      end
    end
  end

  // Boundary register next value, one cell per bit
  genvar gi;
  generate
    for (gi = 0; gi < BSR_LEN; gi = gi + 1) begin : g_bsr
      wire shift_in;
      if (gi == BSR_LEN - 1) begin : g_top
        assign shift_in = tdi_s;
      end else begin : g_mid
        assign shift_in = bsr_shift[gi+1];
      end
      // Capture from the ring, shift towards bit 0, or hold
      assign next_bsr[gi] = st_cap_dr ? ring_s[gi] :
        (st_sh_dr ? shift_in : bsr_shift[gi]);
    end
  endgenerate

  // Boundary shift stage advances on rise when selected
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bsr_shift <= {BSR_LEN{1'b0}};
    end else if (tck_rise && sel_bsr) begin
      bsr_shift <= next_bsr;
    end
  end

  // Boundary update stage holds values for the pin drivers
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bsr_update <= {BSR_LEN{1'b0}};
    end else if (tck_rise && sel_bsr && st_upd_dr) begin
      bsr_update <= bsr_shift;
    end
  end

  // Pin control follows the active instruction; cleared in reset state
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bnd_drive <= 1'b0;
      io_hiz <= 1'b0;
    end else begin
      bnd_drive <= (ir == `MBST_OP_EXTEST) & ~st_reset;
      io_hiz <= (ir == `MBST_OP_SAMPZ) & ~st_reset;
    end
  end

  // Serial output source: one register per shift state and instruction, low in all other states
  always @* begin
    next_tdo = 1'b0;
    if (st_sh_ir) begin
      next_tdo = ir_shift[0];
    end else if (st_sh_dr) begin
      if (sel_bsr) begin
        next_tdo = bsr_shift[0];
      end else if (sel_id) begin
        next_tdo = id_shift[0];
      end else begin
        next_tdo = bypass;
      end
    end
  end

  // Serial output and its enable change only on a falling edge
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= next_tdo;
      tdo_oe <= st_sh_ir | st_sh_dr;
    end
  end

  assign tdo_o = tdo;
  assign tdo_oe_o = tdo_oe;
  assign tap_state_o = state;
  assign instr_o = ir;
  assign bnd_update_o = bsr_update;
  assign bnd_drive_o = bnd_drive;
  assign io_hiz_o = io_hiz;
endmodule

// ===== testbench/mbst_tap_chk.sv
`timescale 1ns/100ps
`include "mbst_map.vh"
// Watches the test port pins and controller state
module mbst_tap_chk (
  input wire clk_sys_i,
  input wire reset_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdo_o,
  input wire tdo_oe_o,
  input wire [3:0] tap_state_o,
  input wire [2:0] instr_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  reg tck_q;
  reg [2:0] hi_cnt;
  // Counts test clock rises with mode select high, saturating at five
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tck_q <= 1'b0;
      hi_cnt <= 3'h0;
    end else begin
      tck_q <= tck_i;
      if (tck_i && !tck_q)
        hi_cnt <= !tms_i ? 3'h0 : (hi_cnt == 3'h5) ? 3'h5 : hi_cnt + 3'h1;
    end
  end
  a_state_on_rise: assert property ($changed(tap_state_o) |-> tck_i)
    else $error("State moved while test clock low");
  a_reset_state: assert property (disable iff (1'b0)
    reset_i |-> tap_state_o == `MBST_ST_RESET && instr_o == `MBST_OP_IDCODE) else $error("Bad power-up state");
  a_reset_preset: assert property (tap_state_o == `MBST_ST_RESET |=> instr_o == `MBST_OP_IDCODE)
    else $error("Instruction not preset in reset state");
  a_five_high: assert property (hi_cnt == 3'h5 |-> ##[0:8] tap_state_o == `MBST_ST_RESET)
    else $error("Five high mode select rises missed reset");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck_i)
    else $error("Data output moved while test clock high");
  a_oe_in_shift: assert property (tdo_oe_o |-> tap_state_o inside
    {`MBST_ST_SH_DR, `MBST_ST_EX1_DR, `MBST_ST_SH_IR, `MBST_ST_EX1_IR}) else $error("Output enabled outside shift");
  a_oe_rise: assert property ($rose(tdo_oe_o) |-> !tck_i &&
    (tap_state_o == `MBST_ST_SH_DR || tap_state_o == `MBST_ST_SH_IR)) else $error("Output enable rose wrongly");
  a_instr_update: assert property ($changed(instr_o) |->
    $past(tap_state_o) == `MBST_ST_UPD_IR || $past(tap_state_o) == `MBST_ST_RESET)
    else $error("Instruction changed outside update");
  c_shift_dr: cover property (tap_state_o == `MBST_ST_SH_DR);
  c_extest: cover property (instr_o == `MBST_OP_EXTEST);
  c_five_high: cover property (hi_cnt == 3'h5);
endmodule
bind mbst_tap mbst_tap_chk chk_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tck_i(tck_i), .tms_i(tms_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .tap_state_o(tap_state_o), .instr_o(instr_o));

// ===== testbench/mbst_ctl_model.sv
`timescale 1ns/100ps
// External test controller; test clock stands low between bits
module mbst_ctl_model (
  input wire clk_sys_i,
  input wire tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  // Idle levels
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // Puts a frame half a nanosecond off the system clock; later edges stay off it
  task automatic frame_start;
    @(posedge clk_sys_i);
    #0.5;
  endtask
  // One 48 ns test clock period; bits follow each other back to back
  task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #24;
    tdo = tdo_i;
    tck_o = 1'b1;
    #24;
    tck_o = 1'b0;
  endtask
endmodule

// ===== testbench/mbst_tap_test.sv
`timescale 1ns/100ps
`include "mbst_map.vh"
module mbst_tap_test;
  logic clk_sys_i;
  logic reset_i;
  logic [106:0] io_ring_i;
  wire tck, tms, tdi, tdo_o, tdo_oe_o, bnd_drive_o, io_hiz_o;
  wire [3:0] tap_state_o;
  wire [2:0] instr_o;
  wire [106:0] bnd_update_o;
  wire tdo_pin;
  int fails = 0;
  int checked = 0;
  logic [127:0] d;
  localparam logic [31:0] ID = {`MBST_ID_REV, `MBST_ID_PART, `MBST_ID_VENDOR, `MBST_ID_FIX};
  mbst_tap dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .io_ring_i(io_ring_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .tap_state_o(tap_state_o), .instr_o(instr_o),
    .bnd_update_o(bnd_update_o), .bnd_drive_o(bnd_drive_o), .io_hiz_o(io_hiz_o));
  // Released output has no pull: the controller sees the inverse of the last level
  assign tdo_pin = tdo_oe_o ? tdo_o : ~tdo_o;
  mbst_ctl_model ctl_u (.clk_sys_i(clk_sys_i), .tdo_i(tdo_pin), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  // System clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Mode select walk, bit 0 first, data input low
  task automatic moves(input int n, input logic [7:0] seq);
    logic b;
    for (int i = 0; i < n; i++)
      ctl_u.bit_io(seq[i], 1'b0, b);
  endtask
  // Shift n bits from a shift state, then back to idle
  task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      ctl_u.bit_io(i == n - 1, din[i], b);
      dout[i] = b;
    end
    moves(2, 8'h01);
  endtask
  task automatic dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    moves(3, 8'h01);
    scan(n, din, dout);
  endtask
  task automatic ir(input logic [2:0] op);
    logic [127:0] cap;
    moves(4, 8'h03);
    scan(3, op, cap);
    chk(cap[2:0], `MBST_IR_CAPTURE);
  endtask
  task automatic t_idcode;
    dr(32, 0, d);
    chk(d[31:0], ID);
    chk(tdo_oe_o, 1'b0);
  endtask
  task automatic t_tms_reset;
    ir(`MBST_OP_BYPASS);
    moves(3, 8'h01);
    moves(5, 8'h1f);
    chk(tap_state_o, `MBST_ST_RESET);
    chk(instr_o, `MBST_OP_IDCODE);
    moves(1, 8'h00);
    t_idcode();
  endtask
  task automatic t_bypass;
    logic [2:0] ops [2] = '{`MBST_OP_BYPASS, 3'h5};
    foreach (ops[k]) begin
      ir(ops[k]);
      dr(8, 8'hb5, d);
      chk(d[7:0], 8'h6a);
    end
  endtask
  task automatic t_boundary;
    logic [2:0] ops [3] = '{`MBST_OP_EXTEST, `MBST_OP_SAMPLE, `MBST_OP_SAMPZ};
    logic [127:0] pat = {4{32'hc3a51e69}};
    logic [106:0] upd;
    foreach (ops[k]) begin
      @(posedge clk_sys_i);
      io_ring_i <= k[0] ? ~pat[106:0] : pat[108:2];
      upd = k[0] ? pat[120:14] : ~pat[125:19];
      ctl_u.frame_start();
      ir(ops[k]);
      chk(instr_o, ops[k]);
      chk(bnd_drive_o, ops[k] == `MBST_OP_EXTEST);
      chk(io_hiz_o, ops[k] == `MBST_OP_SAMPZ);
      dr(107, upd, d);
      chk(d[106:0], io_ring_i);
      chk(bnd_update_o, upd);
    end
  endtask
  // Main sequence
  initial begin
    reset_i <= 1'b1;
    io_ring_i <= '0;
    repeat (2) @(posedge clk_sys_i);
    chk(tap_state_o, `MBST_ST_RESET);
    chk(instr_o, `MBST_OP_IDCODE);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    ctl_u.frame_start();
    moves(1, 8'h00);
    t_idcode();
    t_tms_reset();
    t_bypass();
    t_boundary();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #200us;
    fails++;
    tally_and_finish();
  end
endmodule
